/* File: core/hgt_timer.sv */
/*
  Hang-guard timer: counts down from a programmed timeout in ticks of
  one millisecond once enabled; software services it by writing a key
  pair. On expiry one active-low output is asserted (timeout or reset).
  Assumes synchronous inputs on sys_clk and a one-cycle strobe master.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
// Overview of operation
// (R1) Software must keep servicing after enabling.
// (R2) Timeout when service misses the interval.
// (R3) Expiry drives one active-low output, selected.
// (R4) Enable is sticky until reset.
// (R5) Separate stop and wait suspend settings.
// (R6) Some config bits take first write only.
// (R7) Optional interrupt request beside timeout outputs.
// (R8) Service reloads count and clears pre-expiry.
`timescale 1ns/10ps
module hgt_timer
#(
  parameter bit          HAS_IRQ     = 1'b1,
  parameter int unsigned TICK_CYCLES = hgt_pkg::TICK_CYCLES
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [hgt_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [31:0]              rdata,
  input  wire logic                     stop_mode,
  input  wire logic                     wait_mode,
  output logic                          timeout_n,
  output logic                          sys_reset_n,
  output logic                          irq
);
  // ==========================================================
  // Configuration registers
  logic                      enable;
  logic                      rst_sel;
  logic                      stop_sus;
  logic                      wait_sus;
  logic                      locked;
  logic [hgt_pkg::CNT_W-1:0] timeout_val;
  logic [hgt_pkg::CNT_W-1:0] pretime_val;
  logic [hgt_pkg::ST_W-1:0]  mask;
  logic                      next_enable;
  logic                      next_rst_sel;
  logic                      next_stop_sus;
  logic                      next_wait_sus;
  logic                      next_locked;
  logic [hgt_pkg::CNT_W-1:0] next_timeout_val;
  logic [hgt_pkg::CNT_W-1:0] next_pretime_val;
  logic [hgt_pkg::ST_W-1:0]  next_mask;
  logic                      wr_ctrl;
  logic                      wr_svc;

  assign wr_ctrl = wr_en && (addr == hgt_pkg::OFS_CTRL);
  assign wr_svc  = wr_en && (addr == hgt_pkg::OFS_SERVICE);

  always_comb
  begin
    next_enable      = enable;
    next_rst_sel     = rst_sel;
    next_stop_sus    = stop_sus;
    next_wait_sus    = wait_sus;
    next_locked      = locked;
    next_timeout_val = timeout_val;
    next_pretime_val = pretime_val;
    next_mask        = mask;
    if (wr_ctrl)
    begin
      next_enable = enable | wdata[hgt_pkg::CTRL_ENABLE]; // R4
      if (!locked)
      begin
        // First write only after boot
        next_rst_sel  = wdata[hgt_pkg::CTRL_RST_SEL];  // R6
        next_stop_sus = wdata[hgt_pkg::CTRL_STOP_SUS]; // R6
        next_wait_sus = wdata[hgt_pkg::CTRL_WAIT_SUS]; // R6
        next_locked   = 1'b1;                          // R6
      end
    end
    if (wr_en && (addr == hgt_pkg::OFS_TIMEOUT))
      next_timeout_val = wdata[hgt_pkg::CNT_W-1:0];
    if (wr_en && (addr == hgt_pkg::OFS_PRETIME))
      next_pretime_val = wdata[hgt_pkg::CNT_W-1:0];
    if (wr_en && (addr == hgt_pkg::OFS_MASK))
      next_mask = wdata[hgt_pkg::ST_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      enable      <= 1'b0;
      rst_sel     <= 1'b0;
      stop_sus    <= 1'b0;
      wait_sus    <= 1'b0;
      locked      <= 1'b0;
      timeout_val <= hgt_pkg::TIMEOUT_RST;
      pretime_val <= hgt_pkg::PRETIME_RST;
      mask        <= '0;
    end
    else
    begin
      enable      <= next_enable;
      rst_sel     <= next_rst_sel;
      stop_sus    <= next_stop_sus;
      wait_sus    <= next_wait_sus;
      locked      <= next_locked;
      timeout_val <= next_timeout_val;
      pretime_val <= next_pretime_val;
      mask        <= next_mask;
    end
  end

  // ==========================================================
  // Service key sequence
  logic key_armed;
  logic next_key_armed;
  logic service;

  always_comb
  begin
    next_key_armed = key_armed;
    service        = 1'b0;
    if (wr_svc)
    begin
      if (wdata[hgt_pkg::KEY_W-1:0] == hgt_pkg::KEY_FIRST)
        next_key_armed = 1'b1;
      else if ((wdata[hgt_pkg::KEY_W-1:0] == hgt_pkg::KEY_SECOND) && key_armed)
      begin
        service        = 1'b1;
        next_key_armed = 1'b0;
      end
      else
        next_key_armed = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      key_armed <= 1'b0;
    else
      key_armed <= next_key_armed;
  end

  // ==========================================================
  // Tick divider and countdown
  hgt_pkg::hgt_state_t        state;
  hgt_pkg::hgt_state_t        next_state;
  logic [hgt_pkg::TICK_W-1:0] tick_cnt;
  logic [hgt_pkg::TICK_W-1:0] next_tick_cnt;
  logic [hgt_pkg::CNT_W-1:0]  count;
  logic [hgt_pkg::CNT_W-1:0]  next_count;
  logic [hgt_pkg::PULSE_W-1:0] pulse_cnt;
  logic [hgt_pkg::PULSE_W-1:0] next_pulse_cnt;
  logic                       paused;
  logic                       tick;
  logic                       pre_evt;
  logic                       exp_evt;

  assign paused = (stop_sus && stop_mode) || (wait_sus && wait_mode); // R5
  assign tick   = (tick_cnt == hgt_pkg::TICK_W'(TICK_CYCLES - 1)) && !paused;

  always_comb
  begin
    next_state     = state;
    next_tick_cnt  = tick_cnt;
    next_count     = count;
    next_pulse_cnt = pulse_cnt;
    pre_evt        = 1'b0;
    exp_evt        = 1'b0;
    case (state)
      hgt_pkg::HGT_IDLE:
      begin
        if (enable)
        begin
          next_state    = hgt_pkg::HGT_RUN;
          next_count    = timeout_val;
          next_tick_cnt = '0;
        end
      end
      hgt_pkg::HGT_RUN:
      begin
        if (!paused)                                    // R5
          next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
        if (service)
        begin
          next_count    = timeout_val;                  // R8
          next_tick_cnt = '0;                           // R8
        end
        else if (tick)
        begin
          if (count <= hgt_pkg::CNT_W'(1))
          begin
            next_count     = '0;
            next_state     = hgt_pkg::HGT_EXPIRED;      // R2
            next_pulse_cnt = hgt_pkg::PULSE_W'(hgt_pkg::OUT_PULSE_CYC);
            exp_evt        = 1'b1;                      // R2
          end
          else
          begin
            next_count = count - 1'b1;
            if ((count - 1'b1) == pretime_val)
              pre_evt = 1'b1;
          end
        end
      end
      hgt_pkg::HGT_EXPIRED:
      begin
        if (pulse_cnt != '0)
          next_pulse_cnt = pulse_cnt - 1'b1;
        else if (!rst_sel && service)
        begin
          next_state    = hgt_pkg::HGT_RUN;             // R8
          next_count    = timeout_val;
          next_tick_cnt = '0;
        end
      end
      default:
        next_state = hgt_pkg::HGT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state     <= hgt_pkg::HGT_IDLE;
      tick_cnt  <= '0;
      count     <= '0;
      pulse_cnt <= '0;
    end
    else
    begin
      state     <= next_state;
      tick_cnt  <= next_tick_cnt;
      count     <= next_count;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // ==========================================================
  // Expiry outputs, one selected
  logic next_timeout_n;
  logic next_sys_reset_n;
  logic hold_low;

  assign hold_low = (state == hgt_pkg::HGT_EXPIRED) || exp_evt;

  always_comb
  begin
    next_timeout_n   = !(hold_low && !rst_sel); // R3
    next_sys_reset_n = !(hold_low && rst_sel);  // R3
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      timeout_n   <= 1'b1;
      sys_reset_n <= 1'b1;
    end
    else
    begin
      timeout_n   <= next_timeout_n;
      sys_reset_n <= next_sys_reset_n;
    end
  end

  // ==========================================================
  // Sticky status, clear on read, interrupt
  logic [hgt_pkg::ST_W-1:0] status;
  logic [hgt_pkg::ST_W-1:0] next_status;
  logic [hgt_pkg::ST_W-1:0] evt;
  logic                     rd_status;

  assign rd_status = rd_en && (addr == hgt_pkg::OFS_STATUS);

  always_comb
  begin
    evt                   = '0;
    evt[hgt_pkg::ST_PRE]  = pre_evt;
    evt[hgt_pkg::ST_EXPIRE] = exp_evt;
    next_status = rd_status ? '0 : status;
    if (service)
      next_status[hgt_pkg::ST_PRE] = 1'b0; // R8
    next_status = next_status | evt;       // Set wins over clear
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status <= '0;
    else
      status <= next_status;
  end

  assign irq = HAS_IRQ && |(status & mask); // R7

  // ==========================================================
  // Read data
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = '0;
    if (rd_en)
    begin
      case (addr)
        hgt_pkg::OFS_CTRL:
        begin
          next_rdata[hgt_pkg::CTRL_ENABLE]   = enable;
          next_rdata[hgt_pkg::CTRL_RST_SEL]  = rst_sel;
          next_rdata[hgt_pkg::CTRL_STOP_SUS] = stop_sus;
          next_rdata[hgt_pkg::CTRL_WAIT_SUS] = wait_sus;
          next_rdata[hgt_pkg::CTRL_LOCKED]   = locked;
        end
        hgt_pkg::OFS_TIMEOUT: next_rdata[hgt_pkg::CNT_W-1:0] = timeout_val;
        hgt_pkg::OFS_COUNT:   next_rdata[hgt_pkg::CNT_W-1:0] = count;
        hgt_pkg::OFS_STATUS:  next_rdata[hgt_pkg::ST_W-1:0]  = status;
        hgt_pkg::OFS_MASK:    next_rdata[hgt_pkg::ST_W-1:0]  = mask;
        hgt_pkg::OFS_PRETIME: next_rdata[hgt_pkg::CNT_W-1:0] = pretime_val;
        default:              next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end
endmodule : hgt_timer

/* File: inc/hgt_pkg.sv */
/*
  Constants for the hang-guard timer: register offsets, field positions,
  reset values and timing figures.
  Assumes a 40 MHz system clock and a plain strobe register port.
*/
package hgt_pkg;
  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W        = 16;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned OUT_PULSE_US  = 1;
  localparam int unsigned OUT_PULSE_CYC = (CLK_HZ / 1_000_000) * OUT_PULSE_US;
  localparam int unsigned PULSE_W       = 8;

  // ==========================================================
  // Register map (byte addresses)
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_TIMEOUT   = 8'h04;
  localparam logic [7:0]  OFS_SERVICE   = 8'h08;
  localparam logic [7:0]  OFS_COUNT     = 8'h0C;
  localparam logic [7:0]  OFS_STATUS    = 8'h10;
  localparam logic [7:0]  OFS_MASK      = 8'h14;
  localparam logic [7:0]  OFS_PRETIME   = 8'h18;

  // ==========================================================
  // Control fields
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_RST_SEL  = 1;
  localparam int unsigned CTRL_STOP_SUS = 2;
  localparam int unsigned CTRL_WAIT_SUS = 3;
  localparam int unsigned CTRL_LOCKED   = 4;

  // Status / mask fields
  localparam int unsigned ST_PRE        = 0;
  localparam int unsigned ST_EXPIRE     = 1;
  localparam int unsigned ST_W          = 2;

  // Service key pair
  localparam int unsigned KEY_W         = 16;
  localparam logic [KEY_W-1:0] KEY_FIRST  = 16'h5555;
  localparam logic [KEY_W-1:0] KEY_SECOND = 16'hAAAA;

  // Reset values
  localparam logic [CNT_W-1:0] TIMEOUT_RST = 16'h0400;
  localparam logic [CNT_W-1:0] PRETIME_RST = 16'h0000;

  typedef enum logic [2:0]
  {
    HGT_IDLE    = 3'h1,
    HGT_RUN     = 3'h2,
    HGT_EXPIRED = 3'h4
  } hgt_state_t;
endpackage : hgt_pkg

/* File: testbench/hgt_timer_props.sv */
/*
  Port-level checker for the hang-guard timer, bound into hgt_timer.
  Assumes one clock domain, sys_clk, with the synchronous reset rst.
*/
`timescale 1ns/10ps
module hgt_timer_props
(
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire logic [hgt_pkg::ADDR_W-1:0]   addr,
  input wire logic [31:0]                  wdata,
  input wire logic                         wr_en,
  input wire logic                         rd_en,
  input wire logic [31:0]                  rdata,
  input wire logic                         stop_mode,
  input wire logic                         wait_mode,
  input wire logic                         timeout_n,
  input wire logic                         sys_reset_n,
  input wire logic                         irq
);
  // ==========================================================
  // Shadow of the first control write
  logic       seen;
  logic       next_seen;
  logic       en_seen;
  logic       next_en_seen;
  logic [2:0] saved;
  logic [2:0] next_saved;
  logic       ctrl_wr;
  logic       ctrl_rd;

  assign ctrl_wr = wr_en && (addr == hgt_pkg::OFS_CTRL);

  always_comb
  begin
    next_seen    = seen;
    next_en_seen = en_seen;
    next_saved   = saved;
    if (ctrl_wr)
    begin
      next_seen = 1'b1;
      if (!seen)
        next_saved = wdata[3:1];
      if (wdata[hgt_pkg::CTRL_ENABLE])
        next_en_seen = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    ctrl_rd <= rd_en && (addr == hgt_pkg::OFS_CTRL);
    if (rst)
    begin
      seen    <= 1'b0;
      en_seen <= 1'b0;
      saved   <= 3'h0;
    end
    else
    begin
      seen    <= next_seen;
      en_seen <= next_en_seen;
      saved   <= next_saved;
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence mask_wr;
    wr_en && (addr == hgt_pkg::OFS_MASK);
  endsequence
  sequence mask_rd;
    rd_en && (addr == hgt_pkg::OFS_MASK);
  endsequence

  rst_quiet_a: assert property (disable iff (1'b0) rst |=> timeout_n && sys_reset_n && !irq)
    else $error("outputs not idle after reset");
  rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  out_select_a: assert property (seen |-> (saved[0] ? timeout_n : sys_reset_n))
    else $error("unselected expiry output asserted");
  out_hold_a: assert property ($fell(timeout_n) |=> !timeout_n [*8])
    else $error("timeout output released too early");
  rst_hold_a: assert property ($fell(sys_reset_n) |=> !sys_reset_n [*8])
    else $error("reset request released");
  cfg_lock_a: assert property (seen && ctrl_rd |-> rdata[3:1] == saved)
    else $error("locked control bits changed");
  en_sticky_a: assert property (en_seen && ctrl_rd |-> rdata[hgt_pkg::CTRL_ENABLE])
    else $error("enable dropped");
  mask_rb_a: assert property (mask_wr ##1 mask_rd |=> rdata[1:0] == $past(wdata[1:0], 2))
    else $error("mask readback wrong");
  irq_clear_a: assert property ($fell(irq) |-> $past(wr_en || rd_en))
    else $error("interrupt dropped without access");
endmodule : hgt_timer_props

bind hgt_timer hgt_timer_props u_hgt_timer_props
(
  .sys_clk     (sys_clk),
  .rst         (rst),
  .addr        (addr),
  .wdata       (wdata),
  .wr_en       (wr_en),
  .rd_en       (rd_en),
  .rdata       (rdata),
  .stop_mode   (stop_mode),
  .wait_mode   (wait_mode),
  .timeout_n   (timeout_n),
  .sys_reset_n (sys_reset_n),
  .irq         (irq)
);

/* File: testbench/tb_top.sv */
/*
  Self-checking bench for the hang-guard timer.
  Assumes the checker is bound in and a tick of four clock cycles.
*/
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("BAD %0t got %h want %h", $time, (g), (e)); \
    end \
  end
module tb_top;
  logic        sys_clk, rst, wr_en, rd_en, stop_mode, wait_mode, timeout_n, sys_reset_n, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, d2;
  int          err_count, comparisons, cyc;
  typedef struct { logic [7:0] a; logic [31:0] rv; logic [31:0] wv; logic [31:0] ev; } hgt_row_t;
  hgt_row_t    rows [4] = '{
    '{hgt_pkg::OFS_TIMEOUT, 32'(hgt_pkg::TIMEOUT_RST), 32'h0000_0003, 32'h0000_0003},
    '{hgt_pkg::OFS_PRETIME, 32'(hgt_pkg::PRETIME_RST), 32'h0000_0001, 32'h0000_0001},
    '{8'h1C, 32'h0, 32'hFFFF_FFFF, 32'h0},
    '{hgt_pkg::OFS_MASK, 32'h0, 32'h0000_0003, 32'h0000_0003}};

  hgt_timer #(.HAS_IRQ(1'b1), .TICK_CYCLES(4)) u_hgt_timer
  (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .stop_mode(stop_mode), .wait_mode(wait_mode), .timeout_n(timeout_n),
    .sys_reset_n(sys_reset_n), .irq(irq)
  );

  // ==========================================================
  // Clock, watchdog on the bench itself, verdict
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Register port cycles, all entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr  <= a;
    wdata <= v;
    rd_en <= 1'b0;
    wr_en <= 1'b1;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr  <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
    @(posedge sys_clk);
  endtask : rd

  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // Ends at a falling edge; bounded wait on the selected output
  task automatic wait_out(input bit sel);
    int n;
    n = 0;
    idle(0);
    while ((sel ? sys_reset_n : timeout_n) !== 1'b0 && n < 80)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_out

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst, addr, wdata, wr_en, rd_en, stop_mode, wait_mode} <= {1'b1, 8'h00, 32'h0, 4'h0};
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(hgt_pkg::OFS_CTRL, d);
    `CHK(d, 32'h0)
    foreach (rows[i])
    begin
      rd(rows[i].a, d);
      `CHK(d, rows[i].rv)
      wr(rows[i].a, rows[i].wv);
      rd(rows[i].a, d);
      `CHK(d, rows[i].ev)
    end
    // Enable with stop suspend, then try to disable and relock
    wr(hgt_pkg::OFS_CTRL, 32'h0000_0005);
    wr(hgt_pkg::OFS_CTRL, 32'h0000_000A);
    rd(hgt_pkg::OFS_CTRL, d);
    `CHK(d[3:0], 4'h5)
    repeat (6)
    begin
      wr(hgt_pkg::OFS_SERVICE, 32'(hgt_pkg::KEY_FIRST));
      wr(hgt_pkg::OFS_SERVICE, 32'(hgt_pkg::KEY_SECOND));
      idle(1);
      @(negedge sys_clk);
      `CHK({timeout_n, sys_reset_n, irq}, 3'b110)
      @(posedge sys_clk);
    end
    // Stop mode freezes the count; wait mode alone does not
    stop_mode <= 1'b1;
    idle(2);
    rd(hgt_pkg::OFS_COUNT, d);
    idle(40);
    rd(hgt_pkg::OFS_COUNT, d2);
    `CHK(d2, d)
    `CHK(d, rows[0].ev)
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    wait_out(1'b0);
    `CHK({timeout_n, sys_reset_n, irq}, 3'b011)
    @(posedge sys_clk);
    rd(hgt_pkg::OFS_STATUS, d);
    `CHK(d, 32'h0000_0003)
    @(negedge sys_clk);
    `CHK({timeout_n, irq}, 2'b00)
    @(posedge sys_clk);
    // Second reset: reset request, wait suspend, interrupt masked
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK({timeout_n, sys_reset_n, irq}, 3'b110)
    @(posedge sys_clk);
    wr(hgt_pkg::OFS_TIMEOUT, 32'h0000_0002);
    wr(hgt_pkg::OFS_CTRL, 32'h0000_000B);
    idle(20);
    rd(hgt_pkg::OFS_COUNT, d);
    `CHK(d, 32'h0000_0002)
    wait_mode <= 1'b0;
    wait_out(1'b1);
    `CHK({timeout_n, sys_reset_n, irq}, 3'b100)
    @(posedge sys_clk);
    wr(hgt_pkg::OFS_SERVICE, 32'(hgt_pkg::KEY_FIRST));
    wr(hgt_pkg::OFS_SERVICE, 32'(hgt_pkg::KEY_SECOND));
    idle(45);
    rd(hgt_pkg::OFS_STATUS, d);
    @(negedge sys_clk);
    `CHK({sys_reset_n, d}, {1'b0, 32'h0000_0002})
    give_verdict();
  end
endmodule : tb_top
